// file: bmp_pkg.sv
package bmp_pkg;
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LANE_W = 2;
  // Byte lane positions of the write strobe
  localparam int LANE_HI = 1;
  localparam int LANE_LO = 0;
  // Inactive levels of the active-low outputs
  localparam logic       INACT_N   = 1'h1;
  localparam logic [1:0] STROBE_INACT = 2'h3;
  // Least strobe width and setup/hold, in clocks
  localparam logic [1:0] STROBE_MIN_CLK = 2'h1;
  localparam logic [1:0] SETUP_CLK      = 2'h1;
  localparam logic [1:0] HOLD_CLK       = 2'h1;
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  // Source owning the current transfer
  typedef enum logic [1:0]
  {
    BMP_SRC_ENG  = 2'h1,
    BMP_SRC_HOST = 2'h2
  } bmp_src_t;
endpackage

// file: bmp_strobe.sv
`timescale 1ns/1ps
// One strobe cycle: setup, strobe (stretched by wait), hold.
// Sync mode skips setup and hold; the strobe lasts one clock plus waits.
module bmp_strobe
(
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_start,
  input  wire logic                       i_async,
  input  wire logic                       i_wait_n,
  output logic                            o_setup,
  output logic                            o_strobe,
  output logic                            o_hold,
  output logic                            o_capture,
  output logic                            o_done
);
  // Phase counter shared by setup and hold
  logic [1:0] cnt_reg;
  logic       strobe_end;

  typedef enum logic [3:0]
  {
    BMP_PH_IDLE  = 4'h1,
    BMP_PH_SETUP = 4'h2,
    BMP_PH_STRB  = 4'h4,
    BMP_PH_HOLD  = 4'h8
  } bmp_ph_t;
  bmp_ph_t ph_reg;

  // Strobe ends on a clock where wait is inactive
  assign strobe_end = (ph_reg == BMP_PH_STRB) && i_wait_n;
  assign o_setup    = (ph_reg == BMP_PH_SETUP);
  assign o_strobe   = (ph_reg == BMP_PH_STRB);
  assign o_hold     = (ph_reg == BMP_PH_HOLD);
  // Data is taken on the edge that ends the strobe
  assign o_capture  = strobe_end;
  assign o_done     = (strobe_end && !i_async) ||
                      ((ph_reg == BMP_PH_HOLD) &&
                       (cnt_reg == bmp_pkg::HOLD_CLK));

  // Phase sequencing
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ph_reg  <= BMP_PH_IDLE;
      cnt_reg <= 2'h0;
    end
    else
    begin
      case (ph_reg)
        BMP_PH_IDLE:
        begin
          cnt_reg <= 2'h1;
          if (i_start)
            // Async needs address one clock early
            ph_reg <= i_async ? BMP_PH_SETUP : BMP_PH_STRB;
        end
        BMP_PH_SETUP:
        begin
          if (cnt_reg == bmp_pkg::SETUP_CLK)
            ph_reg <= BMP_PH_STRB;
          cnt_reg <= 2'h1;
        end
        BMP_PH_STRB:
        begin
          // Held while wait low
          if (i_wait_n)
            ph_reg <= i_async ? BMP_PH_HOLD : BMP_PH_IDLE;
        end
        BMP_PH_HOLD:
        begin
          // Address and data stay one clock after strobe
          if (cnt_reg == bmp_pkg::HOLD_CLK)
            ph_reg <= BMP_PH_IDLE;
          else
            cnt_reg <= cnt_reg + 2'h1;
        end
        default:
          ph_reg <= BMP_PH_IDLE;
      endcase
    end
  end
endmodule

// file: bmp_backend_memory_port.sv
`timescale 1ns/1ps
// Operation
// - Hold request low until grant seen
// - On grant, open window, then transfer
// - Window held until all transfers done
// - Two byte write strobes, high and low
// - Sync write strobe stretched by wait
// - Async write: setup and hold one clock
// - Sync read captured when wait inactive
// - Async read captured as strobe rises
// - Chip select timed like the address
// - Control enable only while granted
// - Data enable only for granted writes
// - Mode input: 1 async, 0 sync
// - Host path enable gates host accesses
// - Host wait stretched by grant and wait
module bmp_backend_memory_port
(
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  // Static straps
  input  wire logic                       i_async_backend_select,
  input  wire logic                       i_host_memory_path_enable,
  // Protocol engine requests
  input  wire logic                       i_eng_valid,
  input  wire logic                       i_eng_write,
  input  wire logic                       i_eng_last,
  input  wire logic [1:0]                 i_eng_lanes_n,
  input  wire logic [15:0]                i_eng_address,
  input  wire logic [15:0]                i_eng_write_data,
  output logic                            o_eng_ready,
  output logic                            o_eng_read_valid,
  output logic [15:0]                     o_eng_read_data,
  // Host (CPU) memory access
  input  wire logic                       i_host_read_n,
  input  wire logic [1:0]                 i_host_write_n,
  input  wire logic [15:0]                i_host_address,
  input  wire logic [15:0]                i_host_write_data,
  output logic                            o_host_wait_n,
  output logic [15:0]                     o_host_read_data,
  // Backend memory pins
  output logic                            o_backend_request_n,
  input  wire logic                       i_backend_grant_n,
  output logic                            o_backend_window_n,
  output logic [1:0]                      o_backend_write_strobe_n,
  output logic                            o_backend_read_strobe_n,
  output logic                            o_backend_select_n,
  input  wire logic                       i_backend_wait_n,
  output logic [15:0]                     o_backend_address,
  output logic [15:0]                     o_backend_write_data,
  input  wire logic [15:0]                i_backend_read_data,
  output logic                            o_control_drive_enable,
  output logic                            o_data_drive_enable
);
  // Reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_b;

  // Bus ownership state
  // One-hot codes keep each pin decode to one or two state compares
  typedef enum logic [3:0]
  {
    BMP_ST_IDLE = 4'h1,
    BMP_ST_REQ  = 4'h2,
    BMP_ST_XFER = 4'h4,
    BMP_ST_NEXT = 4'h8
  } bmp_state_t;
  bmp_state_t state_reg;

  bmp_pkg::bmp_src_t src_reg;       // Owner of current window
  logic              write_reg;     // Current transfer is a write
  logic [1:0]        lanes_reg;     // Active-low byte lanes
  logic              last_reg;      // Window closes after this one
  logic              host_done_reg; // Host access served, await release
  // Strobe sequencer handshake and phase flags
  logic              start;         // Kick the strobe sequencer
  logic              ph_setup;      // Address out, strobe not yet low
  logic              ph_strobe;     // Strobe low, stretched by wait
  logic              ph_hold;       // Strobe high, address still held
  logic              capture;       // Read data is valid on this edge
  logic              done;          // Last clock of the transfer
  // Host and engine request decode
  logic              host_rd;       // Host read strobe low
  logic              host_wr;       // Either host write lane low
  logic              host_req;      // Host access waiting to be served
  logic              eng_take;      // Engine beat accepted from idle
  logic              host_take;     // Host access accepted from idle

  // Reset release through two flops
  // Assertion stays asynchronous so the pins go quiet at once; only the
  // release is timed to the clock. That keeps the ownership flops and
  // the strobe sequencer from leaving reset on different edges, which
  // could otherwise start a strobe with no window around it.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_reg <= 1'h0;
      rst_sync_reg <= 1'h0;
    end
    else
    begin
      rst_meta_reg <= 1'h1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_b = rst_sync_reg;

  // Host requests count only when the path is strapped open
  // A closed path leaves the host strobes unseen, so a board that puts
  // host and memory on one shared bus cannot loop an access back onto
  // itself. The done flag masks a strobe that is still held after its
  // access was served, so one host strobe gives exactly one transfer.
  assign host_rd  = !i_host_read_n;
  assign host_wr  = (i_host_write_n != bmp_pkg::STROBE_INACT);
  assign host_req = i_host_memory_path_enable && (host_rd || host_wr) &&
                    !host_done_reg;
  // Engine has priority; host waits for an idle port
  // Both takes look only at the idle state, so a new owner can never
  // slip in while a window is open. The cost is that a steady engine
  // stream can hold the host off; the host wait output covers that.
  assign eng_take  = (state_reg == BMP_ST_IDLE) && i_eng_valid;
  assign host_take = (state_reg == BMP_ST_IDLE) && !i_eng_valid && host_req;
  // Ready is combinational: a beat is taken on the edge where it is high,
  // either from idle or between beats of an open engine window
  assign o_eng_ready = eng_take ||
                       ((state_reg == BMP_ST_NEXT) &&
                        (src_reg == bmp_pkg::BMP_SRC_ENG) && i_eng_valid);

  // Sequencer starts on entry to a transfer
  // In the request state the start coincides with the grant being seen,
  // so the first strobe phase lines up with the window opening; between
  // engine beats it coincides with the next beat being taken. A beat
  // that is not yet offered simply leaves the window open and idle.
  assign start = ((state_reg == BMP_ST_REQ) && !i_backend_grant_n) ||
                 (state_reg == BMP_ST_NEXT && o_eng_ready);

  // Strobe timing lives in its own sequencer so that the ownership
  // machine never needs to know the backend mode; only done and
  // capture, with the setup, strobe and hold flags for the pins, come back from it.
  bmp_strobe u_strobe
  (
    .i_clk     (i_clk),
    .i_rst_b   (rst_b),
    .i_start   (start),
    .i_async   (i_async_backend_select),
    .i_wait_n  (i_backend_wait_n),
    .o_setup   (ph_setup),
    .o_strobe  (ph_strobe),
    .o_hold    (ph_hold),
    .o_capture (capture),
    .o_done    (done)
  );

  // Ownership sequencing
  // Idle, request, transfer and between-beats. The window output follows
  // the last two states, so it cannot drop between beats of one window
  // and cannot open before the grant has been sampled low. There is no
  // limit on the grant delay; the arbiter is trusted to answer.
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= BMP_ST_IDLE;
    else
    begin
      case (state_reg)
        BMP_ST_IDLE:
          if (eng_take || host_take)
            state_reg <= BMP_ST_REQ;
        BMP_ST_REQ:
          // Grant sampled directly, it is synchronous
          if (!i_backend_grant_n)
            state_reg <= BMP_ST_XFER;
        BMP_ST_XFER:
          // Grant is no longer looked at here
          if (done)
            state_reg <= last_reg ? BMP_ST_IDLE : BMP_ST_NEXT;
        BMP_ST_NEXT:
          // Window stays open while more engine words come
          if (o_eng_ready)
            state_reg <= BMP_ST_XFER;
        default:
          state_reg <= BMP_ST_IDLE;
      endcase
    end
  end

  // Latch the transfer that is taken
  // Address and write data are registered pins, loaded only on a take.
  // They therefore stay put through setup, strobe and hold, which is
  // what gives the asynchronous mode its clock of setup and of hold.
  // Nothing else may load them, or a hold clock would see a new address.
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_reg              <= bmp_pkg::BMP_SRC_ENG;
      write_reg            <= 1'h0;
      lanes_reg            <= bmp_pkg::STROBE_INACT;
      last_reg             <= 1'h1;
      o_backend_address    <= bmp_pkg::ADDR_RST;
      o_backend_write_data <= bmp_pkg::DATA_RST;
    end
    else if (o_eng_ready)
    begin
      src_reg              <= bmp_pkg::BMP_SRC_ENG;
      write_reg            <= i_eng_write;
      lanes_reg            <= i_eng_lanes_n;
      last_reg             <= i_eng_last;
      o_backend_address    <= i_eng_address;
      o_backend_write_data <= i_eng_write_data;
    end
    else if (host_take)
    begin
      // Host always a single access per window
      src_reg              <= bmp_pkg::BMP_SRC_HOST;
      write_reg            <= host_wr;
      lanes_reg            <= i_host_write_n;
      last_reg             <= 1'h1;
      o_backend_address    <= i_host_address;
      o_backend_write_data <= i_host_write_data;
    end
  end

  // Host handshake: done flag held until strobes released
  // Setting wins over clearing, so a served access is never lost even if
  // the host drops its strobe on the very clock that finishes it.
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
      host_done_reg <= 1'h0;
    else if (done && (state_reg == BMP_ST_XFER) &&
             (src_reg == bmp_pkg::BMP_SRC_HOST))
      host_done_reg <= 1'h1;
    else if (!host_rd && !host_wr)
      host_done_reg <= 1'h0;
  end
  // Host waits through grant delay and memory waits
  // Wait is combinational from the host strobes, so it falls in the same
  // clock that the access is asked for and no clock of grant delay or
  // memory wait is missed from the stretch.
  assign o_host_wait_n = !(i_host_memory_path_enable &&
                           (host_rd || host_wr) && !host_done_reg);

  // Read data capture on the strobe-ending edge
  // In sync mode that edge is the one where wait is seen inactive; in
  // async mode it is the edge on which the read strobe returns high.
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_eng_read_valid <= 1'h0;
      o_eng_read_data  <= bmp_pkg::DATA_RST;
      o_host_read_data <= bmp_pkg::DATA_RST;
    end
    else
    begin
      o_eng_read_valid <= 1'h0;
      if (capture && !write_reg && (state_reg == BMP_ST_XFER))
      begin
        if (src_reg == bmp_pkg::BMP_SRC_HOST)
          o_host_read_data <= i_backend_read_data;
        else
        begin
          o_eng_read_data  <= i_backend_read_data;
          o_eng_read_valid <= 1'h1;
        end
      end
    end
  end

  // Pin outputs; reset forces every one inactive
  // All are decoded from reset-cleared state, so no pin can glitch active
  // while the synchronised reset is still held.
  assign o_backend_request_n = !(state_reg == BMP_ST_REQ);
  assign o_backend_window_n  = !((state_reg == BMP_ST_XFER) ||
                                 (state_reg == BMP_ST_NEXT));
  // Per-lane write strobes
  assign o_backend_write_strobe_n = (ph_strobe && write_reg) ?
                                    lanes_reg : bmp_pkg::STROBE_INACT;
  assign o_backend_read_strobe_n  = !(ph_strobe && !write_reg);
  // Select covers setup, strobe and hold like the address
  // It stays high in the request state: the control lines are not yet
  // driven there, and a select before the grant would reach a bus that
  // another master still owns.
  assign o_backend_select_n = !(ph_setup || ph_strobe || ph_hold);
  // Driven only while owning a granted window
  // The window opens only after grant was sampled low with the request
  // out, so the enable cannot turn on for a bus that is not ours.
  assign o_control_drive_enable = !o_backend_window_n;
  // Data driven only for a granted write
  assign o_data_drive_enable = !o_backend_window_n && write_reg &&
                               (state_reg == BMP_ST_XFER);
endmodule

// file: bmp_properties.sv
`timescale 1ns/1ps
// Pin-level watch on the memory side of the port
module bmp_properties
(
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_async_backend_select,
  input wire logic        i_host_memory_path_enable,
  input wire logic        o_host_wait_n,
  input wire logic        o_backend_request_n,
  input wire logic        i_backend_grant_n,
  input wire logic        o_backend_window_n,
  input wire logic [1:0]  o_backend_write_strobe_n,
  input wire logic        o_backend_read_strobe_n,
  input wire logic        o_backend_select_n,
  input wire logic        i_backend_wait_n,
  input wire logic [15:0] o_backend_address,
  input wire logic        o_control_drive_enable,
  input wire logic        o_data_drive_enable
);
  // Any strobe low; one net keeps the properties short
  wire stb = !o_backend_read_strobe_n || o_backend_write_strobe_n != 2'h3;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Request pending, then grant seen
  sequence s_pend;
    !o_backend_request_n && i_backend_grant_n;
  endsequence
  sequence s_grant;
    !o_backend_request_n && !i_backend_grant_n;
  endsequence
  // Async strobe edges, where setup and hold clocks apply
  sequence s_on;
    i_async_backend_select && $rose(stb);
  endsequence
  sequence s_off;
    i_async_backend_select && $fell(stb);
  endsequence
  req_hold_a: assert property (s_pend |=> !o_backend_request_n)
    else $error("request dropped before grant");
  win_open_a: assert property (s_grant |=> !o_backend_window_n)
    else $error("window not opened after grant");
  stb_window_a: assert property (stb |-> !o_backend_window_n)
    else $error("strobe outside window");
  stb_select_a: assert property (stb |-> !o_backend_select_n)
    else $error("strobe without select");
  sel_window_a: assert property
    (!o_backend_select_n |-> !o_backend_window_n)
    else $error("select outside window");
  async_setup_a: assert property
    (s_on |-> !$past(o_backend_select_n) && $stable(o_backend_address))
    else $error("no setup clock");
  async_hold_a: assert property
    (s_off |-> !o_backend_select_n && $stable(o_backend_address))
    else $error("no hold clock");
  wait_stretch_a: assert property
    (stb && !i_backend_wait_n |=> stb && $stable(o_backend_write_strobe_n))
    else $error("strobe ended during wait");
  ctrl_en_a: assert property
    ($rose(o_control_drive_enable) |->
     !$past(o_backend_request_n) && !$past(i_backend_grant_n))
    else $error("control enable while not granted");
  data_en_a: assert property
    (o_backend_write_strobe_n != 2'h3 |-> o_data_drive_enable)
    else $error("write without data enable");
  host_block_a: assert property
    (!i_host_memory_path_enable |-> o_host_wait_n)
    else $error("host stalled on closed path");
  read_drive_a: assert property
    (!o_backend_read_strobe_n |-> !o_data_drive_enable)
    else $error("data driven during read");
endmodule
bind bmp_backend_memory_port bmp_properties u_props (.*);

// file: bmp_memory_model.sv
`timescale 1ns/1ps
// Shared memory and its arbiter, prompt or slow
module bmp_memory_model
(
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_request_n,
  input  wire logic        i_window_n,
  input  wire logic [1:0]  i_write_strobe_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_select_n,
  input  wire logic [15:0] i_address,
  input  wire logic [15:0] i_write_data,
  output logic             o_grant_n,
  output logic             o_wait_n,
  output logic [15:0]      o_read_data
);
  logic [15:0] mem [256];           // Low address byte decodes only
  logic [15:0] junk_reg = 16'h5a3c; // Moving pattern off the bus
  logic [1:0]  gcnt_reg = 2'h0;     // Grant delay count
  logic [1:0]  wcnt_reg = 2'h0;     // Wait clocks given this strobe
  logic        gnt_reg  = 1'b1;
  wire stb = !i_read_strobe_n || i_write_strobe_n != 2'h3;
  // Slow memory holds wait for two clocks of each strobe
  assign o_wait_n = !(i_slow && stb && wcnt_reg != 2'h2);
  assign o_grant_n = gnt_reg;
  // Never show the last word once released
  assign o_read_data = (!i_select_n && !i_read_strobe_n) ?
                       mem[i_address[7:0]] : junk_reg;
  // Clocked grant, dropped as soon as the window opens
  always @(posedge i_clk)
  begin
    junk_reg <= junk_reg + 16'h1357;
    wcnt_reg <= !stb ? 2'h0 : (o_wait_n ? wcnt_reg : wcnt_reg + 2'h1);
    if (!i_window_n || i_request_n)
    begin
      gnt_reg <= 1'b1;
      gcnt_reg <= 2'h0;
    end
    else if (gcnt_reg == (i_slow ? 2'h3 : 2'h0))
      gnt_reg <= 1'b0;
    else
      gcnt_reg <= gcnt_reg + 2'h1;
    // Byte lanes land on a strobe clock without wait
    if (!i_select_n && o_wait_n && !i_write_strobe_n[1])
      mem[i_address[7:0]][15:8] <= i_write_data[15:8];
    if (!i_select_n && o_wait_n && !i_write_strobe_n[0])
      mem[i_address[7:0]][7:0] <= i_write_data[7:0];
  end
endmodule

// file: bmp_backend_memory_port_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module bmp_backend_memory_port_tb_top;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_async_backend_select = 1'b0;
  logic        i_host_memory_path_enable = 1'b1;
  logic        i_eng_valid = 1'b0;
  logic        i_eng_write = 1'b0;
  logic        i_eng_last = 1'b0;
  logic [1:0]  i_eng_lanes_n = 2'h3;
  logic [15:0] i_eng_address = 16'h0;
  logic [15:0] i_eng_write_data = 16'h0;
  logic        i_host_read_n = 1'b1;
  logic [1:0]  i_host_write_n = 2'h3;
  logic [15:0] i_host_address = 16'h0;
  logic [15:0] i_host_write_data = 16'h0;
  logic        slow = 1'b0;
  logic        o_eng_ready, o_eng_read_valid, o_host_wait_n;
  logic [15:0] o_eng_read_data, o_host_read_data, i_backend_read_data;
  logic        o_backend_request_n, i_backend_grant_n, o_backend_window_n;
  logic [1:0]  o_backend_write_strobe_n;
  logic        o_backend_read_strobe_n, o_backend_select_n, i_backend_wait_n;
  logic [15:0] o_backend_address, o_backend_write_data;
  logic        o_control_drive_enable, o_data_drive_enable;
  int          bad_count = 0;
  int          check_count = 0;
  int unsigned seed = 18905; // Fixed start of the xorshift stream
  int          exp_mem [256]; // Bench copy of memory
  int          exp_q [$];     // Engine reads not yet returned
  int          wt [4];        // Host read wait clocks per mode
  int          n;
  logic [15:0] a;
  wire [7:0]   idle_pins = {o_backend_request_n, o_backend_window_n,
    o_backend_write_strobe_n, o_backend_read_strobe_n, o_backend_select_n,
    o_control_drive_enable, o_data_drive_enable};
  bmp_backend_memory_port u_dut (.*);
  bmp_memory_model u_mem
  (
    .i_clk            (i_clk),
    .i_slow           (slow),
    .i_request_n      (o_backend_request_n),
    .i_window_n       (o_backend_window_n),
    .i_write_strobe_n (o_backend_write_strobe_n),
    .i_read_strobe_n  (o_backend_read_strobe_n),
    .i_select_n       (o_backend_select_n),
    .i_address        (o_backend_address),
    .i_write_data     (o_backend_write_data),
    .o_grant_n        (i_backend_grant_n),
    .o_wait_n         (i_backend_wait_n),
    .o_read_data      (i_backend_read_data)
  );
  initial
    forever #5 i_clk = ~i_clk;
  // Xorshift step
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Reset with the straps set for the coming test
  task automatic reset(input logic as, pe);
    @(negedge i_clk);
    i_rst_b = 1'b0;
    i_async_backend_select = as;
    i_host_memory_path_enable = pe;
    repeat (5) @(negedge i_clk);
    `CHK("idle pins", 8'hfc, idle_pins)
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask
  // Engine beat held until taken; bench copy follows the lanes
  task automatic eng(input logic w, l, input logic [1:0] ln,
                     input logic [15:0] d);
    @(negedge i_clk);
    {i_eng_valid, i_eng_write, i_eng_last, i_eng_lanes_n} = {1'b1, w, l, ln};
    i_eng_address = a;
    i_eng_write_data = d;
    // Ready is combinational: look only once the new inputs have settled
    #1;
    for (n = 0; n < 40 && o_eng_ready !== 1'b1; n++)
    begin
      @(negedge i_clk);
      #1;
    end
    `CHK("eng taken", 1'b1, o_eng_ready)
    @(posedge i_clk);
    if (!w)
      exp_q.push_back(exp_mem[a[7:0]]);
    if (w && !ln[1])
      exp_mem[a[7:0]][15:8] = d[15:8];
    if (w && !ln[0])
      exp_mem[a[7:0]][7:0] = d[7:0];
  endtask
  // Host access; n ends as the clocks spent stalled
  task automatic host(input logic rd, input logic [15:0] d);
    @(negedge i_clk);
    i_eng_valid = 1'b0;
    i_host_address = a;
    i_host_write_data = d;
    i_host_read_n = !rd;
    i_host_write_n = {2{rd}};
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (o_host_wait_n !== 1'b1 && n < 40);
    `CHK("host served", 1'b1, o_host_wait_n)
    if (rd)
      `CHK("host read", exp_mem[a[7:0]][15:0], o_host_read_data)
    else
      exp_mem[a[7:0]] = d;
    i_host_read_n = 1'b1;
    i_host_write_n = 2'h3;
  endtask
  // Each returned engine read against the oldest expected word
  always @(negedge i_clk)
    if (o_eng_read_valid === 1'b1)
    begin
      `CHK("eng read", exp_q[0][15:0], o_eng_read_data)
      void'(exp_q.pop_front());
    end
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      reset(m[0], 1'b1);
      slow = m[1];
      a = rnd();
      // Three lane patterns into one word, then three reads back to back
      eng(1'b1, 1'b0, 2'h0, rnd());
      eng(1'b1, 1'b0, 2'h1, rnd());
      eng(1'b1, 1'b1, 2'h2, rnd());
      for (int i = 0; i < 3; i++)
        eng(1'b0, i == 2, 2'h3, 16'h0);
      a = a + 16'h5;
      host(1'b0, rnd());
      host(1'b1, 16'h0);
      wt[m] = n;
      repeat (8) @(negedge i_clk);
      $display("test async %0d slow %0d done", m[0], m[1]);
    end
    `CHK("slow host stall sync", 1'b1, wt[2] > wt[0])
    `CHK("slow host stall async", 1'b1, wt[3] > wt[1])
    // Shared-bus strap: host traffic refused outright
    reset(1'b0, 1'b0);
    i_host_read_n = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK("refused", 2'h3, {o_host_wait_n, o_backend_request_n})
    i_host_read_n = 1'b1;
    `CHK("reads left", 0, exp_q.size())
    print_verdict();
  end
  // Hang guard, far beyond the few hundred clocks needed
  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
